// ---- ewl_map.svh ----
`ifndef EWL_MAP_SVH
`define EWL_MAP_SVH
`define EWL_CMD1       8'haa
`define EWL_CMD2       8'h55
`define EWL_CMD3       8'ha0
`define EWL_PAT1       12'h555
`define EWL_PAT2       12'haaa
`define EWL_PAT_MSB    11
`define EWL_MAX_DATA   7'h40
`define EWL_RSV_MASK   16'h007f
`define EWL_LOCK_RST   1'b0
`endif

// ---- ewl_pkg.sv ----
package ewl_pkg;
    typedef enum logic [2:0] {
        EWL_IDLE,
        EWL_GOT1,
        EWL_GOT2,
        EWL_OPEN,
        EWL_ARM
    } ewl_state_t;
endpackage

// ---- ewl_seq.sv ----
`include "ewl_map.svh"
// Summary of operation
// [R01] Command bytes AAh, 55h, A0h in order.
// [R02] Match only low address bits 555/AAA/555.
// [R03] Locked: writes need the unlock sequence first.
// [R04] Up to sixty-four data bytes follow.
// [R05] Lock state kept in nonvolatile bit.
// [R06] Nonvolatile bit delivered disabled.
// [R07] Enable needs dummy write at region start.
// [R08] Host places region on 128-byte boundary.
// [R09] Already locked: no dummy write needed.
// [R10] Host must not enable without dummy.
// [R11] Host saves and restores region contents.
// [R12] Every re-enable repeats the dummy write.
// [R13] Locked writes without unlock are dropped.
// [R14] Broken order returns matcher to idle.
module ewl_seq #(
    parameter int AW = 16
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // Host write strobe, one cycle, same clock domain
    input  wire logic          wr_stb,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    // Nonvolatile lock bit as loaded at power-up and its erase request
    input  wire logic          nv_lock_in,
    input  wire logic          nv_load,
    input  wire logic          lock_erase,
    // Memory write port
    output logic               mem_we,
    output logic [AW-1:0]      mem_addr,
    output logic [7:0]         mem_data,
    // Lock state
    output logic               eeprom_write_lock
);
    // =========================================================
    // Parameter check
    // =========================================================
    // The matcher compares a fixed number of low address bits, so a
    // narrower bus cannot be served.
    if (AW < `EWL_PAT_MSB + 1) begin : g_aw_check
        $error("ewl_seq: AW must cover the matched address bits");
    end

    // =========================================================
    // Decode
    // =========================================================
    ewl_pkg::ewl_state_t st_ff;
    ewl_pkg::ewl_state_t nxt_st;
    logic [6:0]          cnt_ff;
    logic [6:0]          nxt_cnt;
    logic                lock_ff;
    logic                nxt_lock;
    logic                we_ff;
    logic                nxt_we;
    logic [AW-1:0]       addr_ff;
    logic [7:0]          data_ff;

    wire [`EWL_PAT_MSB:0] low_addr = wr_addr[`EWL_PAT_MSB:0];
    wire is_c1 = (wr_data == `EWL_CMD1) && (low_addr == `EWL_PAT1); // R01 R02
    wire is_c2 = (wr_data == `EWL_CMD2) && (low_addr == `EWL_PAT2);
    wire is_c3 = (wr_data == `EWL_CMD3) && (low_addr == `EWL_PAT1);
    wire rsv_start = (wr_addr & AW'(`EWL_RSV_MASK)) == '0;
    wire burst_full = (cnt_ff == `EWL_MAX_DATA);

    // =========================================================
    // Sequence matcher
    // =========================================================
    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_lock = lock_ff;
        nxt_we   = 1'b0;
        if (wr_stb) begin
            case (st_ff)
                ewl_pkg::EWL_IDLE: begin
                    if (is_c1) begin
                        nxt_st = ewl_pkg::EWL_GOT1;
                    end else begin
                        nxt_we = !lock_ff; // R13
                    end
                end
                ewl_pkg::EWL_GOT1: begin
                    nxt_st = is_c2 ? ewl_pkg::EWL_GOT2
                                   : ewl_pkg::EWL_IDLE; // R14
                end
                ewl_pkg::EWL_GOT2: begin
                    nxt_cnt = '0;
                    if (!is_c3) begin
                        nxt_st = ewl_pkg::EWL_IDLE; // R14
                    end else if (lock_ff) begin
                        nxt_st = ewl_pkg::EWL_OPEN; // R03 R09
                    end else begin
                        nxt_st = ewl_pkg::EWL_ARM; // R07
                    end
                end
                ewl_pkg::EWL_ARM: begin
                    // Only a write at a region start sets the lock; any
                    // other byte is an ordinary unlocked write.
                    nxt_st = ewl_pkg::EWL_IDLE;
                    nxt_we = 1'b1;
                    if (rsv_start) begin
                        nxt_lock = 1'b1; // R07
                        nxt_we   = 1'b0;
                    end
                end
                ewl_pkg::EWL_OPEN: begin
                    if (is_c1) begin
                        nxt_st = ewl_pkg::EWL_GOT1;
                    end else if (!burst_full) begin
                        nxt_we  = 1'b1; // R04
                        nxt_cnt = cnt_ff + 7'h01;
                    end else begin
                        nxt_st = ewl_pkg::EWL_IDLE; // R13
                    end
                end
                default: nxt_st = ewl_pkg::EWL_IDLE;
            endcase
        end
        if (lock_erase) begin
            nxt_lock = 1'b0; // R05
        end
        if (nv_load) begin
            nxt_lock = nv_lock_in; // R05
        end
    end

    // =========================================================
    // Registers
    // =========================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff   <= ewl_pkg::EWL_IDLE;
            cnt_ff  <= '0;
            lock_ff <= `EWL_LOCK_RST; // R06
            we_ff   <= 1'b0;
            addr_ff <= '0;
            data_ff <= '0;
        end else begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            lock_ff <= nxt_lock;
            we_ff   <= nxt_we;
            addr_ff <= wr_addr;
            data_ff <= wr_data;
        end
    end

    assign mem_we            = we_ff;
    assign mem_addr          = addr_ff;
    assign mem_data          = data_ff;
    assign eeprom_write_lock = lock_ff;

    // =========================================================
    // Checks
    // =========================================================
    property p_lock_drop;
        @(posedge ref_clk) disable iff (rst)
        (wr_stb && lock_ff && st_ff == ewl_pkg::EWL_IDLE && !is_c1)
            |=> !mem_we;
    endproperty
    a_lock_drop: assert property (p_lock_drop) // R13
        else $error("locked write passed without unlock");

    property p_break;
        @(posedge ref_clk) disable iff (rst)
        (wr_stb && st_ff == ewl_pkg::EWL_GOT1 && !is_c2)
            |=> st_ff == ewl_pkg::EWL_IDLE;
    endproperty
    a_break: assert property (p_break) // R14
        else $error("matcher did not return to idle");

    property p_arm_lock;
        @(posedge ref_clk) disable iff (rst)
        (wr_stb && st_ff == ewl_pkg::EWL_ARM && rsv_start
            && !lock_erase && !nv_load) |=> lock_ff && !mem_we;
    endproperty
    a_arm_lock: assert property (p_arm_lock) // R07
        else $error("dummy write did not set lock");

    property p_open_wr;
        @(posedge ref_clk) disable iff (rst)
        (wr_stb && st_ff == ewl_pkg::EWL_OPEN && !is_c1 && !burst_full)
            |=> mem_we && mem_addr == $past(wr_addr);
    endproperty
    a_open_wr: assert property (p_open_wr) // R04
        else $error("unlocked data byte not written");

    property p_seq;
        @(posedge ref_clk) disable iff (rst)
        (wr_stb && st_ff == ewl_pkg::EWL_GOT2 && is_c3 && lock_ff)
            |=> st_ff == ewl_pkg::EWL_OPEN;
    endproperty
    a_seq: assert property (p_seq) // R09
        else $error("unlock sequence not accepted");

    property p_no_set;
        @(posedge ref_clk) disable iff (rst)
        (!lock_ff && st_ff != ewl_pkg::EWL_ARM && !nv_load) |=> !lock_ff;
    endproperty
    a_no_set: assert property (p_no_set) // R07
        else $error("lock set without dummy write");

    property p_cmd_take;
        @(posedge ref_clk) disable iff (rst)
        (wr_stb && st_ff == ewl_pkg::EWL_IDLE && is_c1)
            |=> st_ff == ewl_pkg::EWL_GOT1 && !mem_we;
    endproperty
    a_cmd_take: assert property (p_cmd_take) // R01
        else $error("first command byte not taken");

    property p_burst_end;
        @(posedge ref_clk) disable iff (rst)
        (wr_stb && st_ff == ewl_pkg::EWL_OPEN && !is_c1 && burst_full)
            |=> !mem_we && st_ff == ewl_pkg::EWL_IDLE;
    endproperty
    a_burst_end: assert property (p_burst_end) // R04
        else $error("byte beyond burst limit written");

    property p_third_break;
        @(posedge ref_clk) disable iff (rst)
        (wr_stb && st_ff == ewl_pkg::EWL_GOT2 && !is_c3)
            |=> st_ff == ewl_pkg::EWL_IDLE && !mem_we;
    endproperty
    a_third_break: assert property (p_third_break) // R14
        else $error("broken third step not dropped");

    property p_lock_keep;
        @(posedge ref_clk) disable iff (rst)
        (lock_ff && !lock_erase && !nv_load) |=> lock_ff;
    endproperty
    a_lock_keep: assert property (p_lock_keep) // R05
        else $error("lock cleared without erase");
endmodule // ewl_seq

// ---- ewl_host.sv ----
module ewl_host (
    // Clock and write port seen back
    input  wire logic        ref_clk,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_data,
    // Host byte bus
    output logic             wr_stb,
    output logic [15:0]      wr_addr,
    output logic [7:0]       wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        got_we;
    logic [15:0] got_addr;
    logic [7:0]  got_data;
    initial begin
        wr_stb = 1'b0;
        wr_addr = 16'h0000;
        wr_data = 8'h00;
    end
    // Strobe stays up between bytes, so bursts run back to back.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        wr_stb = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge ref_clk);
        got_we = mem_we;
        got_addr = mem_addr;
        got_data = mem_data;
    endtask
    // A released bus shows inverted values so no stale byte looks valid.
    task automatic idle();
        wr_stb = 1'b0;
        wr_addr = ~wr_addr;
        wr_data = ~wr_data;
        @(negedge ref_clk);
    endtask
    task automatic unlock(input logic [3:0] x);
        wr({x, 12'h555}, 8'haa);
        wr({x, 12'haaa}, 8'h55);
        wr({x, 12'h555}, 8'ha0);
    endtask
endmodule // ewl_host

// ---- testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk;
    logic        rst;
    logic        nv_lock_in;
    logic        nv_load;
    logic        lock_erase;
    logic        wr_stb;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;
    logic        mem_we;
    logic [15:0] mem_addr;
    logic [7:0]  mem_data;
    logic        lock;
    int          n_errors = 0;
    int          checks_done = 0;
    ewl_seq dut_u (.ref_clk(ref_clk), .rst(rst), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data), .nv_lock_in(nv_lock_in),
        .nv_load(nv_load), .lock_erase(lock_erase), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_data(mem_data), .eeprom_write_lock(lock));
    ewl_host host_u (.ref_clk(ref_clk), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_data(mem_data), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // =======================================
    // Checks
    task automatic chk_bit(input logic g, input logic e, input string m);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic chk_word(input logic [15:0] g, e, input string m);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic nv_pulse(input logic ld, input logic er);
        nv_load = ld;
        lock_erase = er;
        @(negedge ref_clk);
        nv_load = 1'b0;
        lock_erase = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic written(input logic [15:0] a, input logic [7:0] d,
                           input logic e);
        host_u.wr(a, d);
        chk_bit(host_u.got_we, e, "write strobe");
        if (e) begin
            chk_word(host_u.got_addr, a, "write address");
            chk_word({8'h00, host_u.got_data}, {8'h00, d}, "write data");
        end
    endtask
    // =======================================
    // Scenarios
    task automatic t_power();
        chk_bit(lock, 1'b0, "lock after reset");
        nv_lock_in = 1'b1;
        nv_pulse(1'b1, 1'b0);
        chk_bit(lock, 1'b1, "lock restore");
        nv_pulse(1'b0, 1'b1);
        chk_bit(lock, 1'b0, "lock erase");
    endtask
    task automatic t_enable();
        written(16'h1234, 8'h5a, 1'b1);
        host_u.unlock(4'h3);
        written(16'h3001, 8'h77, 1'b1);
        chk_bit(lock, 1'b0, "enable without dummy");
        host_u.unlock(4'h8);
        written(16'h8080, 8'hee, 1'b0);
        host_u.idle();
        chk_bit(lock, 1'b1, "enable by dummy");
    endtask
    task automatic t_locked();
        written(16'h1234, 8'h5a, 1'b0);
        host_u.wr(16'h2555, 8'haa);
        host_u.wr(16'h2aaa, 8'h12);
        host_u.wr(16'h2555, 8'ha0);
        host_u.wr(16'h2555, 8'haa);
        host_u.wr(16'h2aaa, 8'h55);
        written(16'h2555, 8'ha1, 1'b0);
        written(16'h2100, 8'h33, 1'b0);
        host_u.unlock(4'h5);
        for (int i = 0; i < 64; i++) begin
            written(16'h5000 + 16'(i), 8'(i), 1'b1);
        end
        written(16'h5040, 8'h99, 1'b0);
        host_u.idle();
    endtask
    task automatic t_reen();
        nv_pulse(1'b0, 1'b1);
        host_u.unlock(4'h1);
        written(16'h1105, 8'h11, 1'b1);
        host_u.unlock(4'h1);
        written(16'h1100, 8'h00, 1'b0);
        host_u.idle();
        chk_bit(lock, 1'b1, "re-enable");
    endtask
    initial begin
        rst = 1'b1;
        nv_lock_in = 1'b0;
        nv_load = 1'b0;
        lock_erase = 1'b0;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        t_power();
        t_enable();
        t_locked();
        t_reen();
        stop_test();
    end
endmodule // testbench
